// File: src/sgcfg_consts.svh
`ifndef SGCFG_CONSTS_SVH
`define SGCFG_CONSTS_SVH

// ============================================================
// Geometry.
`define SGCFG_PREFETCH     8
`define SGCFG_DQ_W         32
`define SGCFG_BYTE_W       8
`define SGCFG_BYTES        4
`define SGCFG_ADDR_LANES   9
`define SGCFG_CMD_PINS     4
`define SGCFG_BANK_W       4
`define SGCFG_ROW_W        14
`define SGCFG_COL_W        7

// ============================================================
// Command balls, indexed by ball.
`define SGCFG_BALL_G12     0
`define SGCFG_BALL_L12     1
`define SGCFG_BALL_G3      2
`define SGCFG_BALL_L3      3

// ============================================================
// Address lanes, named first half then second half.
`define SGCFG_LN_BA3_A3    0
`define SGCFG_LN_BA2_A4    1
`define SGCFG_LN_BA1_A5    2
`define SGCFG_LN_BA0_A2    3
`define SGCFG_LN_A12_A13   4
`define SGCFG_LN_A11_A6    5
`define SGCFG_LN_A10_A0    6
`define SGCFG_LN_A9_A1     7
`define SGCFG_LN_A8_A7     8

// ============================================================
// Field positions and configuration.
`define SGCFG_ROW_A8       8
`define SGCFG_COL_A6       6
`define SGCFG_WDET_PIN     1
`define SGCFG_X16_OFF      4'h3

`endif

// File: src/sgcfg_front_end.sv
// Functional notes
// - Mirror high swaps bytes, inversion flags, address pairs.
// - Logic uses logical names; only pin mapping changes.
// - Width detected at fixed error-code ball.
// - Narrow mode: disabled bytes read as zero, termination off.
// - Width latched at reset rise, then frozen.
// - Commands taken on true command clock rise.
// - Address taken on both command clock rises.
// - Write data beat on each forwarded clock rise.
// - First address half latched with command.
// - Second half latched on complement rise.
// - Eight beats form one prefetch access.
// - Row, bank, column, auto-precharge decode.
// - Chip reset low resets, disables termination.
`include "sgcfg_consts.svh"

module sgcfg_front_end #(
    parameter int  PREFETCH = `SGCFG_PREFETCH,
    localparam int DW       = `SGCFG_DQ_W,
    localparam int NB       = `SGCFG_BYTES
) (
    // System clock and reset.
    input  wire logic                       clk_sys_in,
    input  wire logic                       rst_in,
    // Link clocks and straps.
    input  wire logic                       cmd_clk_true_in,
    input  wire logic                       cmd_clk_comp_in,
    input  wire logic                       fwd_data_clk_true_in,
    input  wire logic                       fwd_data_clk_comp_in,
    input  wire logic                       chip_reset_n_in,
    input  wire logic                       mirror_select_in,
    // Physical balls.
    input  wire logic [`SGCFG_CMD_PINS-1:0]   pin_cmd_in,
    input  wire logic [`SGCFG_ADDR_LANES-1:0] pin_addr_in,
    input  wire logic [DW-1:0]                pin_dq_in,
    input  wire logic [NB-1:0]                pin_byte_invert_flag_n_in,
    input  wire logic [NB-1:0]                pin_error_code_in,
    // Write burst framing.
    input  wire logic                       burst_start_in,
    // Configuration.
    output logic                            x16_mode_out,
    output logic                            mirror_mode_out,
    output logic                            config_set_out,
    output logic [NB-1:0]                   byte_active_out,
    output logic [NB-1:0]                   odt_en_out,
    // Decoded command.
    output logic                            cmd_valid_out,
    output sgcfg_pkg::sgcfg_req_s           cmd_out,
    // Write data.
    output logic                            wdata_valid_out,
    output logic [PREFETCH*DW-1:0]          wdata_out,
    output logic [PREFETCH*NB-1:0]          winvert_n_out
);

    localparam int BW = $clog2(PREFETCH);

    // Elaboration stops here when the beat counter could not wrap cleanly at the burst end.
    if (PREFETCH < 2 || (PREFETCH & (PREFETCH - 1)) != 0) begin
        $error("PREFETCH must be a power of two of at least 2.");
    end

    // ============================================================
    // State.
    typedef struct packed {
        sgcfg_pkg::sgcfg_pins_s     s1;
        sgcfg_pkg::sgcfg_pins_s     s2;
        logic                       ck_t_d;
        logic                       ck_c_d;
        logic                       fwd_data_clk_true_d;
        logic                       fwd_data_clk_comp_d;
        logic                       rst_n_d;
        sgcfg_pkg::sgcfg_cfg_s      cfg;
        sgcfg_pkg::sgcfg_cmd_s      cmd_hold;
        logic [`SGCFG_ADDR_LANES-1:0] half1;
        logic                       pend;
        logic                       cmd_valid;
        sgcfg_pkg::sgcfg_req_s      req;
        logic [BW-1:0]              beat;
        logic [PREFETCH*DW-1:0]     shift;
        logic [PREFETCH*NB-1:0]     shinv;
        logic                       wvalid;
        logic [PREFETCH*DW-1:0]     wdata;
        logic [PREFETCH*NB-1:0]     winv;
        logic [NB-1:0]              odt;
        logic [NB-1:0]              act;
    } sgcfg_state_s;

    sgcfg_state_s r_reg;
    sgcfg_state_s r_next;

    // ============================================================
    // Pin mapping helpers.
    function automatic logic [`SGCFG_ADDR_LANES-1:0] addr_logical(
        input logic [`SGCFG_ADDR_LANES-1:0] p,
        input logic                         m
    );
        logic [`SGCFG_ADDR_LANES-1:0] l;
        l = p;
        if (m) begin
            l[`SGCFG_LN_BA3_A3] = p[`SGCFG_LN_BA1_A5];
            l[`SGCFG_LN_BA1_A5] = p[`SGCFG_LN_BA3_A3];
            l[`SGCFG_LN_BA2_A4] = p[`SGCFG_LN_BA0_A2];
            l[`SGCFG_LN_BA0_A2] = p[`SGCFG_LN_BA2_A4];
            l[`SGCFG_LN_A11_A6] = p[`SGCFG_LN_A9_A1];
            l[`SGCFG_LN_A9_A1]  = p[`SGCFG_LN_A11_A6];
            l[`SGCFG_LN_A10_A0] = p[`SGCFG_LN_A8_A7];
            l[`SGCFG_LN_A8_A7]  = p[`SGCFG_LN_A10_A0];
        end
        return l;
    endfunction

    function automatic sgcfg_pkg::sgcfg_cmd_s cmd_logical(
        input logic [`SGCFG_CMD_PINS-1:0] p,
        input logic                       m
    );
        sgcfg_pkg::sgcfg_cmd_s c;
        c.cs_n  = m ? p[`SGCFG_BALL_L12] : p[`SGCFG_BALL_G12];
        c.we_n  = m ? p[`SGCFG_BALL_G12] : p[`SGCFG_BALL_L12];
        c.ras_n = m ? p[`SGCFG_BALL_L3]  : p[`SGCFG_BALL_G3];
        c.cas_n = m ? p[`SGCFG_BALL_G3]  : p[`SGCFG_BALL_L3];
        return c;
    endfunction

    function automatic logic [NB-1:0] flags_logical(input logic [NB-1:0] p, input logic m);
        logic [NB-1:0] r;
        r = {<<{p}};
        return m ? r : p;
    endfunction

    function automatic logic [DW-1:0] dq_logical(
        input logic [DW-1:0] p,
        input logic          m,
        input logic [NB-1:0] act
    );
        logic [DW-1:0] l;
        logic [DW-1:0] sw;
        sw = {<<`SGCFG_BYTE_W{p}};
        l  = m ? sw : p;
        for (int i = 0; i < NB; i++) begin
            l[i*`SGCFG_BYTE_W +: `SGCFG_BYTE_W] &= {`SGCFG_BYTE_W{act[i]}};
        end
        return l;
    endfunction

    // Both halves are already in logical lane order here.
    function automatic sgcfg_pkg::sgcfg_req_s decode(
        input logic [`SGCFG_ADDR_LANES-1:0] h1,
        input logic [`SGCFG_ADDR_LANES-1:0] h2,
        input sgcfg_pkg::sgcfg_cmd_s        c,
        input logic                         x16
    );
        sgcfg_pkg::sgcfg_req_s q;
        q.cmd  = c;
        q.bank = {h1[`SGCFG_LN_BA3_A3], h1[`SGCFG_LN_BA2_A4],
                  h1[`SGCFG_LN_BA1_A5], h1[`SGCFG_LN_BA0_A2]};
        q.row  = {h2[`SGCFG_LN_A12_A13], h1[`SGCFG_LN_A12_A13], h1[`SGCFG_LN_A11_A6],
                  h1[`SGCFG_LN_A10_A0], h1[`SGCFG_LN_A9_A1], h1[`SGCFG_LN_A8_A7],
                  h2[`SGCFG_LN_A8_A7], h2[`SGCFG_LN_A11_A6], h2[`SGCFG_LN_BA1_A5],
                  h2[`SGCFG_LN_BA2_A4], h2[`SGCFG_LN_BA3_A3], h2[`SGCFG_LN_BA0_A2],
                  h2[`SGCFG_LN_A9_A1], h2[`SGCFG_LN_A10_A0]};
        q.col  = q.row[`SGCFG_COL_W-1:0];
        if (!x16) begin
            q.col[`SGCFG_COL_A6] = 1'b0;
        end
        q.auto_pre = h1[`SGCFG_LN_A8_A7];
        return q;
    endfunction

    // ============================================================
    // Edge detection on synchronised pins.
    logic          ck_t_rise;
    logic          ck_c_rise;
    logic          wck_rise;
    logic          rst_rise;
    logic [BW-1:0] beat_now;

    // The synchronisers reset low, so a phase that idles high shows one false rise after reset.
    // Nothing is pending at that point, and burst_start_in realigns the beat count before data.
    assign ck_t_rise = r_reg.s2.ck_t & ~r_reg.ck_t_d;
    assign ck_c_rise = r_reg.s2.ck_c & ~r_reg.ck_c_d;
    assign wck_rise  = (r_reg.s2.fwd_data_clk_true & ~r_reg.fwd_data_clk_true_d) | (r_reg.s2.fwd_data_clk_comp & ~r_reg.fwd_data_clk_comp_d);
    assign rst_rise  = r_reg.s2.rst_n & ~r_reg.rst_n_d;
    assign beat_now  = burst_start_in ? '0 : r_reg.beat;

    // ============================================================
    // Next state.
    always_comb begin
        r_next = r_reg;
        r_next.s1 = {cmd_clk_true_in, cmd_clk_comp_in, fwd_data_clk_true_in, fwd_data_clk_comp_in,
                     chip_reset_n_in, mirror_select_in, pin_cmd_in, pin_addr_in, pin_dq_in,
                     pin_byte_invert_flag_n_in, pin_error_code_in};
        r_next.s2 = r_reg.s1;
        r_next.ck_t_d  = r_reg.s2.ck_t;
        r_next.ck_c_d  = r_reg.s2.ck_c;
        r_next.fwd_data_clk_true_d = r_reg.s2.fwd_data_clk_true;
        r_next.fwd_data_clk_comp_d = r_reg.s2.fwd_data_clk_comp;
        r_next.rst_n_d = r_reg.s2.rst_n;
        r_next.cmd_valid = 1'b0;
        r_next.wvalid    = 1'b0;

        // The strap and the detect ball are caught only on the reset rise.
        if (rst_rise) begin
            r_next.cfg.x16    = ~r_reg.s2.edc[`SGCFG_WDET_PIN];
            r_next.cfg.mirror = r_reg.s2.mf;
            r_next.cfg.set    = 1'b1;
        end
        r_next.act = ~flags_logical(r_next.cfg.x16 ? `SGCFG_X16_OFF : '0, r_next.cfg.mirror);

        if (!r_reg.s2.rst_n) begin
            r_next.odt  = '0;
            r_next.pend = 1'b0;
            r_next.beat = '0;
        end else begin
            r_next.odt = r_next.cfg.set ? ~(r_next.cfg.x16 ? `SGCFG_X16_OFF : '0) : '0;
            if (ck_c_rise && r_reg.pend) begin
                r_next.req = decode(r_reg.half1, addr_logical(r_reg.s2.addr, r_reg.cfg.mirror),
                                    r_reg.cmd_hold, r_reg.cfg.x16);
                r_next.cmd_valid = 1'b1;
                r_next.pend      = 1'b0;
            end
            if (ck_t_rise) begin
                r_next.cmd_hold = cmd_logical(r_reg.s2.cmd, r_reg.cfg.mirror);
                r_next.half1    = addr_logical(r_reg.s2.addr, r_reg.cfg.mirror);
                r_next.pend     = 1'b1;
            end
            r_next.beat = beat_now;
            // Each rise of either forwarded clock phase carries one beat.
            if (wck_rise) begin
                r_next.shift[beat_now*DW +: DW] = dq_logical(r_reg.s2.dq, r_reg.cfg.mirror, r_reg.act);
                r_next.shinv[beat_now*NB +: NB] =
                    flags_logical(r_reg.s2.dbi, r_reg.cfg.mirror) | ~r_reg.act;
                r_next.beat = BW'(beat_now + 1'b1);
                if (beat_now == BW'(PREFETCH - 1)) begin
                    r_next.wvalid = 1'b1;
                    r_next.wdata  = r_next.shift;
                    r_next.winv   = r_next.shinv;
                end
            end
        end
    end

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    // ============================================================
    // Outputs.
    assign x16_mode_out    = r_reg.cfg.x16;
    assign mirror_mode_out = r_reg.cfg.mirror;
    assign config_set_out  = r_reg.cfg.set;
    assign byte_active_out = r_reg.act;
    assign odt_en_out      = r_reg.odt;
    assign cmd_valid_out   = r_reg.cmd_valid;
    assign cmd_out         = r_reg.req;
    assign wdata_valid_out = r_reg.wvalid;
    assign wdata_out       = r_reg.wdata;
    assign winvert_n_out   = r_reg.winv;

    // ============================================================
    // Assertions.
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (rst_in);

    a_cfg_frozen: assert property (!rst_rise |=> $stable(r_reg.cfg))
        else $error("Configuration changed without a reset rise.");
    a_width_latch: assert property (rst_rise |=> x16_mode_out == !$past(r_reg.s2.edc[`SGCFG_WDET_PIN]))
        else $error("Width not taken from the detect ball.");
    a_cmd_on_comp: assert property (cmd_valid_out |-> $past(ck_c_rise) && $past(r_reg.pend))
        else $error("Command issued without a complement rise.");
    a_cmd_true_only: assert property (!ck_t_rise |=> $stable(r_reg.cmd_hold))
        else $error("Command pins taken off the true rise.");
    a_mirror_cs: assert property (ck_t_rise && r_reg.cfg.mirror && r_reg.s2.rst_n
                                  |=> r_reg.cmd_hold.cs_n == $past(r_reg.s2.cmd[`SGCFG_BALL_L12]))
        else $error("Chip select not swapped in mirrored mode.");
    a_col_a6_x32: assert property (cmd_valid_out && !x16_mode_out |-> !cmd_out.col[`SGCFG_COL_A6])
        else $error("Column bit A6 used in full width.");
    a_ap_from_a8: assert property (cmd_valid_out |-> cmd_out.auto_pre == cmd_out.row[`SGCFG_ROW_A8])
        else $error("Auto-precharge not taken from A8.");
    a_odt_reset: assert property (!r_reg.s2.rst_n |=> odt_en_out == '0)
        else $error("Termination on during chip reset.");
    a_odt_x16: assert property (x16_mode_out |-> (odt_en_out & `SGCFG_X16_OFF) == '0)
        else $error("Disabled bytes terminated in narrow mode.");
    a_beat_step: assert property (wck_rise && r_reg.s2.rst_n
                                  |=> r_reg.beat == BW'($past(beat_now) + 1'b1))
        else $error("Beat counter did not advance on a forwarded rise.");
    a_burst_end: assert property (wdata_valid_out |-> r_reg.beat == '0 && $past(wck_rise))
        else $error("Burst closed off the last beat.");

    c_cmd_x16: cover property (cmd_valid_out && x16_mode_out);
    c_mirror_burst: cover property (wdata_valid_out && mirror_mode_out);
    c_cfg_latch: cover property (rst_rise ##1 config_set_out);
    c_reset_again: cover property (config_set_out && !r_reg.s2.rst_n);

endmodule

// File: src/sgcfg_pkg.sv
`include "sgcfg_consts.svh"

package sgcfg_pkg;

    typedef struct packed {
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
    } sgcfg_cmd_s;

    typedef struct packed {
        sgcfg_cmd_s                 cmd;
        logic [`SGCFG_BANK_W-1:0]   bank;
        logic [`SGCFG_ROW_W-1:0]    row;
        logic [`SGCFG_COL_W-1:0]    col;
        logic                       auto_pre;
    } sgcfg_req_s;

    typedef struct packed {
        logic x16;
        logic mirror;
        logic set;
    } sgcfg_cfg_s;

    typedef struct packed {
        logic                          ck_t;
        logic                          ck_c;
        logic                          fwd_data_clk_true;
        logic                          fwd_data_clk_comp;
        logic                          rst_n;
        logic                          mf;
        logic [`SGCFG_CMD_PINS-1:0]    cmd;
        logic [`SGCFG_ADDR_LANES-1:0]  addr;
        logic [`SGCFG_DQ_W-1:0]        dq;
        logic [`SGCFG_BYTES-1:0]       dbi;
        logic [`SGCFG_BYTES-1:0]       edc;
    } sgcfg_pins_s;

endpackage

// File: verification/sgcfg_ctrl_model.sv
module sgcfg_ctrl_model (
    // Timing and strap view.
    input  wire logic        clk_sys_in,
    input  wire logic        mirror_in,
    // Command and address balls.
    output logic             ck_t_out,
    output logic             ck_c_out,
    output logic [3:0]       cmd_out,
    output logic [8:0]       addr_out,
    // Data balls.
    output logic             fwd_data_clk_true_out,
    output logic             fwd_data_clk_comp_out,
    output logic [31:0]      dq_out,
    output logic [3:0]       dbi_n_out,
    output logic             burst_start_out
);
    timeunit 1ns / 100ps;

    localparam int MAP [9] = '{2, 3, 0, 1, 4, 7, 8, 5, 6};
    logic [36:0] beats[$];
    logic        step = 1'h0;
    int          bs_cnt = 0;

    initial begin
        {ck_t_out, fwd_data_clk_true_out, burst_start_out} = 3'h0;
        {ck_c_out, fwd_data_clk_comp_out} = 2'h3;
        cmd_out = 4'hF;
        addr_out = 9'h0AA;
        dq_out = 32'h5A5AC3C3;
        dbi_n_out = 4'h6;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_in);
        #1;
    endtask

    function automatic logic [8:0] place(input logic [8:0] l);
        place = l;
        for (int p = 0; p < 9; p++) begin
            if (mirror_in)
                place[p] = l[MAP[p]];
        end
    endfunction

    // ============================================================
    // Command frame: the command clock stands still between frames.
    task automatic send_cmd(input sgcfg_pkg::sgcfg_cmd_s c, input logic [3:0] ba, input logic [13:0] a);
        tick(1);
        addr_out = place({a[8], a[9], a[10], a[11], a[12], ba[0], ba[1], ba[2], ba[3]});
        cmd_out = mirror_in ? {c.ras_n, c.cas_n, c.cs_n, c.we_n} : {c.cas_n, c.ras_n, c.we_n, c.cs_n};
        tick(2);
        ck_t_out = 1'h1;
        ck_c_out = 1'h0;
        tick(2);
        addr_out = place({a[7], a[1], a[0], a[6], a[13], a[2], a[5], a[4], a[3]});
        cmd_out = ~cmd_out;
        tick(2);
        ck_t_out = 1'h0;
        ck_c_out = 1'h1;
        tick(2);
        addr_out = ~addr_out;
    endtask

    // ============================================================
    // Forwarded clock runs free; an idle bus carries a changing pattern.
    always @(posedge clk_sys_in) begin
        logic [36:0] b;
        #1;
        burst_start_out = (bs_cnt == 1);
        if (bs_cnt != 0)
            bs_cnt--;
        if (!step) begin
            fwd_data_clk_true_out = ~fwd_data_clk_true_out;
            fwd_data_clk_comp_out = ~fwd_data_clk_true_out;
        end else if (beats.size() != 0) begin
            b = beats.pop_front();
            if (b[36])
                bs_cnt = 3;
            dq_out = mirror_in ? {b[7:0], b[15:8], b[23:16], b[31:24]} : b[31:0];
            dbi_n_out = mirror_in ? {b[32], b[33], b[34], b[35]} : b[35:32];
        end else begin
            dq_out = ~dq_out;
            dbi_n_out = ~dbi_n_out;
        end
        step = ~step;
    end
endmodule

// File: verification/sgram_addr_clock_config_tb.sv
module sgram_addr_clock_config_tb;
    timeunit 1ns / 100ps;

    logic                  clk_sys_in = 1'h0;
    logic                  rst_in = 1'h1;
    logic                  chip_reset_n_in = 1'h0;
    logic                  mirror_select_in = 1'h0;
    logic [3:0]            pin_error_code_in = 4'hF;
    logic                  cmd_clk_true_in, cmd_clk_comp_in, fwd_data_clk_true_in, fwd_data_clk_comp_in;
    logic                  burst_start_in, x16_mode_out, mirror_mode_out, config_set_out;
    logic                  cmd_valid_out, wdata_valid_out;
    logic [3:0]            pin_cmd_in, pin_byte_invert_flag_n_in, byte_active_out, odt_en_out, exp_act;
    logic [8:0]            pin_addr_in;
    logic [31:0]           pin_dq_in, winvert_n_out;
    logic [255:0]          wdata_out;
    sgcfg_pkg::sgcfg_req_s cmd_out;
    int                    n_errors = 0;
    int                    check_count = 0;

    always #5 clk_sys_in = ~clk_sys_in;

    sgcfg_front_end DUT (.clk_sys_in, .rst_in, .cmd_clk_true_in, .cmd_clk_comp_in, .fwd_data_clk_true_in,
        .fwd_data_clk_comp_in, .chip_reset_n_in, .mirror_select_in, .pin_cmd_in, .pin_addr_in, .pin_dq_in,
        .pin_byte_invert_flag_n_in, .pin_error_code_in, .burst_start_in, .x16_mode_out, .mirror_mode_out,
        .config_set_out, .byte_active_out, .odt_en_out, .cmd_valid_out, .cmd_out, .wdata_valid_out,
        .wdata_out, .winvert_n_out);

    sgcfg_ctrl_model m_model (.clk_sys_in, .mirror_in(mirror_select_in), .ck_t_out(cmd_clk_true_in),
        .ck_c_out(cmd_clk_comp_in), .cmd_out(pin_cmd_in), .addr_out(pin_addr_in),
        .fwd_data_clk_true_out(fwd_data_clk_true_in), .fwd_data_clk_comp_out(fwd_data_clk_comp_in), .dq_out(pin_dq_in),
        .dbi_n_out(pin_byte_invert_flag_n_in), .burst_start_out(burst_start_in));

    // ============================================================
    // Shared tasks.
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_in);
        #1;
    endtask

    task automatic check(input string what, input logic [255:0] seen, input logic [255:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic conclude;
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // ============================================================
    // Scenarios.
    task automatic set_config(input logic m, input logic n);
        int hits;
        hits = 0;
        exp_act = n ? (m ? 4'h3 : 4'hC) : 4'hF;
        tick(1);
        chip_reset_n_in = 1'h0;
        mirror_select_in = m;
        pin_error_code_in[1] = ~n;
        tick(4);
        check("odt_in_reset", 256'(odt_en_out), 256'h0);
        fork
            m_model.send_cmd(sgcfg_pkg::sgcfg_cmd_s'(4'h1), 4'h5, 14'h1234);
            repeat (20) begin
                tick(1);
                hits += int'(cmd_valid_out === 1'h1);
            end
        join
        check("cmd_in_reset", 256'(hits), 256'h0);
        tick(1);
        chip_reset_n_in = 1'h1;
        tick(8);
        check("x16", 256'(x16_mode_out), 256'(n));
        check("mirror", 256'(mirror_mode_out), 256'(m));
        check("config_set", 256'(config_set_out), 256'h1);
        check("byte_active", 256'(byte_active_out), 256'(exp_act));
        check("odt", 256'(odt_en_out), n ? 256'hC : 256'hF);
        pin_error_code_in[1] = n;
        tick(8);
        check("x16_frozen", 256'(x16_mode_out), 256'(n));
        pin_error_code_in[1] = ~n;
    endtask

    task automatic do_cmd(input logic [3:0] ba, input logic [13:0] a, input logic n);
        sgcfg_pkg::sgcfg_req_s exp;
        logic                  got;
        got = 1'h0;
        exp.cmd = sgcfg_pkg::sgcfg_cmd_s'(ba);
        exp.bank = ba;
        exp.row = a;
        exp.col = n ? a[6:0] : {1'h0, a[5:0]};
        exp.auto_pre = a[8];
        fork
            m_model.send_cmd(exp.cmd, ba, a);
            for (int i = 0; i < 40 && !got; i++) begin
                tick(1);
                got = (cmd_valid_out === 1'h1);
                if (got)
                    check("cmd_out", 256'(cmd_out), 256'(exp));
            end
        join
        check("cmd_valid", 256'(got), 256'h1);
    endtask

    task automatic do_burst(input logic [31:0] seed);
        logic [255:0] ed;
        logic [31:0]  ei;
        logic [31:0]  w;
        logic [3:0]   inv;
        logic         got;
        got = 1'h0;
        for (int k = 0; k < 8; k++) begin
            w = seed + 32'h01234567 * 32'(k);
            inv = 4'(k) + seed[3:0];
            m_model.beats.push_back({k == 0, inv, w});
            for (int b = 0; b < 4; b++) begin
                ed[32*k+8*b+:8] = exp_act[b] ? w[8*b+:8] : 8'h00;
                ei[4*k+b] = exp_act[b] ? inv[b] : 1'h1;
            end
        end
        for (int j = 0; j < 100 && m_model.beats.size() != 0; j++)
            @(posedge clk_sys_in);
        for (int j = 0; j < 20 && !got; j++) begin
            tick(1);
            got = (wdata_valid_out === 1'h1);
        end
        check("wdata_valid", 256'(got), 256'h1);
        check("wdata", wdata_out, ed);
        check("winvert", 256'(winvert_n_out), 256'(ei));
    endtask

    // ============================================================
    // Main sequence and watchdog.
    initial begin
        tick(5);
        rst_in = 1'h0;
        tick(4);
        check("config_idle", 256'(config_set_out), 256'h0);
        for (int i = 0; i < 4; i++) begin
            set_config(i[1], i[0]);
            do_cmd(4'(i * 5 + 3), 14'h3F5F ^ 14'(i), i[0]);
            do_cmd(4'(12 - i), 14'h10A0 ^ 14'(i * 512), i[0]);
            do_burst(32'hC0DE0000 + 32'(i));
            do_burst(32'h3A61F00D ^ 32'(i * 99));
        end
        conclude;
    end

    initial begin
        repeat (5000) @(posedge clk_sys_in);
        n_errors++;
        conclude;
    end
endmodule
